// >>> swdp_port.sv
// serial wire debug port, target side, with one access port stub
// assumes an external probe drives swclk; data pin needs a pull-up
module swdp_port #(
  parameter logic [31:0] ID_CODE = 32'h1234_5671, // value is arbitrary
  parameter logic [3:0] AP_REVISION = 4'h0, // value is arbitrary
  parameter logic [10:0] AP_DESIGNER = 11'h155, // value is arbitrary
  parameter logic [7:0] AP_ID = 8'h01, // value is arbitrary
  parameter int unsigned AP_LATENCY = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic swclk,
  input wire logic swdio_in,
  output logic swdio_out,
  output logic swdio_oe,
  output logic dbg_abort,
  output logic [31:0] ctrl_stat,
  output logic [31:0] wire_ctrl
);
  if (AP_LATENCY < 1 || AP_LATENCY > 255) begin : g_bad_latency
    $error("AP_LATENCY out of range");
  end

  swdp_sync_if lnk();
  swdp_link_sampler u_smp (
    .clk(clk),
    .nrst(nrst),
    .swclk(swclk),
    .swdio_in(swdio_in),
    .lnk(lnk)
  );

  swdp_pkg::swdp_state_e st_reg, st_next;
  logic [5:0] cnt_reg, cnt_next;
  logic [5:0] hi_reg, hi_next;
  logic [7:0] req_reg, req_next;
  logic [32:0] sh_reg, sh_next;
  logic [2:0] ack_reg, ack_next;
  logic active_reg, active_next;
  logic [31:0] sel_reg, sel_next;
  logic [31:0] csr_reg, csr_next;
  logic [31:0] wcr_reg, wcr_next;
  logic [31:0] rdbuf_reg, rdbuf_next;
  logic [31:0] resend_reg, resend_next;
  logic [7:0] busy_reg, busy_next;
  logic wbuf_full_reg, wbuf_full_next;
  logic abort_reg, abort_next;
  logic out_reg, out_next;
  logic oe_reg, oe_next;

  function automatic logic [31:0] ap_read(input logic [7:0] addr);
    if (addr == swdp_pkg::AP_IDENT_OFFSET) begin
      ap_read = {AP_REVISION, AP_DESIGNER, swdp_pkg::AP_TYPE_MEM, 5'h0,
        AP_ID};
    end else begin
      ap_read = 32'h0;
    end
  endfunction

  logic req_ap, req_rd, req_par_ok;
  logic [1:0] req_a;
  logic [7:0] ap_addr;
  logic always_ok, sticky_any;
  assign req_ap = req_reg[1];
  assign req_rd = req_reg[2];
  assign req_a = req_reg[4:3];
  assign req_par_ok = ^req_reg[5:0] == 1'b0 && req_reg[6] == 1'b0;
  assign ap_addr = {sel_reg[7:4], req_a, 2'h0};
  assign always_ok = !req_ap && ((req_rd && req_a != swdp_pkg::DP_ADDR_RDBUF
    && (req_a == swdp_pkg::DP_ADDR_ID_ABORT ||
    (req_a == swdp_pkg::DP_ADDR_CTRL && !sel_reg[0])))
    || (!req_rd && req_a == swdp_pkg::DP_ADDR_ID_ABORT));
  assign sticky_any = csr_reg[swdp_pkg::CSR_ERR_BIT] |
    csr_reg[swdp_pkg::CSR_WDE_BIT] | csr_reg[swdp_pkg::CSR_ORUN_BIT];

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    hi_next = hi_reg;
    req_next = req_reg;
    sh_next = sh_reg;
    ack_next = ack_reg;
    active_next = active_reg;
    sel_next = sel_reg;
    csr_next = csr_reg;
    wcr_next = wcr_reg;
    rdbuf_next = rdbuf_reg;
    resend_next = resend_reg;
    busy_next = busy_reg;
    wbuf_full_next = wbuf_full_reg;
    abort_next = 1'b0;
    out_next = out_reg;
    oe_next = oe_reg;
    // posted access-port operation and write buffer drain
    if (busy_reg != 8'h0) begin
      busy_next = busy_reg - 8'h1;
    end else begin
      wbuf_full_next = 1'b0;
    end
    // run of high data bits for line reset
    if (lnk.clk_rise) begin
      if (!lnk.dio_level) begin
        hi_next = 6'h0;
      end else if (hi_reg != 6'h3f) begin
        hi_next = hi_reg + 6'h1;
      end
    end
    if (lnk.clk_rise) begin
      case (st_reg)
        swdp_pkg::SWDP_LINE_RESET: begin
          if (lnk.dio_level) begin
            cnt_next = 6'h0;
          end else if (cnt_reg == 6'(swdp_pkg::IDLE_LOW_CYC - 1)) begin
            st_next = swdp_pkg::SWDP_IDLE;
            cnt_next = 6'h0;
          end else begin
            cnt_next = cnt_reg + 6'h1;
          end
        end
        swdp_pkg::SWDP_IDLE: begin
          if (lnk.dio_level) begin
            req_next = 8'h01;
            cnt_next = 6'h1;
            st_next = swdp_pkg::SWDP_REQ;
          end
        end
        swdp_pkg::SWDP_REQ: begin
          req_next[cnt_reg[2:0]] = lnk.dio_level;
          cnt_next = cnt_reg + 6'h1;
          if (cnt_reg == 6'h7) begin
            st_next = swdp_pkg::SWDP_TURN_ACK;
            cnt_next = 6'h0;
          end
        end
        swdp_pkg::SWDP_TURN_ACK: begin
          st_next = swdp_pkg::SWDP_ACK;
          cnt_next = 6'h0;
          if (!req_par_ok) begin
            ack_next = 3'h0;
            csr_next[swdp_pkg::CSR_ERR_BIT] = 1'b1;
          end else if (!active_reg && !(req_rd && !req_ap &&
              req_a == swdp_pkg::DP_ADDR_ID_ABORT)) begin
            ack_next = swdp_pkg::ACK_FAULT;
          end else if (always_ok) begin
            ack_next = swdp_pkg::ACK_OK;
          end else if (sticky_any && (req_ap || (!req_rd &&
              req_a == swdp_pkg::DP_ADDR_RDBUF))) begin
            ack_next = swdp_pkg::ACK_FAULT;
          end else if (wbuf_full_reg || busy_reg != 8'h0) begin
            ack_next = swdp_pkg::ACK_WAIT;
          end else begin
            ack_next = swdp_pkg::ACK_OK;
          end
        end
        swdp_pkg::SWDP_ACK: begin
          cnt_next = cnt_reg + 6'h1;
          if (cnt_reg == 6'h2) begin
            cnt_next = 6'h0;
            if (ack_reg == swdp_pkg::ACK_OK ||
                csr_reg[swdp_pkg::CSR_ORUNDET_BIT]) begin
              st_next = swdp_pkg::SWDP_DATA;
              if (!req_rd) begin
                st_next = swdp_pkg::SWDP_TURN_END;
              end
            end else begin
              st_next = swdp_pkg::SWDP_TURN_END;
            end
            if (ack_reg != swdp_pkg::ACK_OK &&
                csr_reg[swdp_pkg::CSR_ORUNDET_BIT]) begin
              csr_next[swdp_pkg::CSR_ORUN_BIT] = 1'b1;
            end
          end
        end
        swdp_pkg::SWDP_DATA: begin
          if (!req_rd) begin
            sh_next[cnt_reg] = lnk.dio_level;
          end
          cnt_next = cnt_reg + 6'h1;
          if (cnt_reg == 6'd32) begin
            cnt_next = 6'h0;
            st_next = req_rd ? swdp_pkg::SWDP_TURN_END : swdp_pkg::SWDP_IDLE;
          end
        end
        swdp_pkg::SWDP_TURN_END: begin
          cnt_next = 6'h0;
          st_next = (!req_rd && ack_reg == swdp_pkg::ACK_OK &&
            cnt_reg == 6'h0) ? swdp_pkg::SWDP_DATA : swdp_pkg::SWDP_IDLE;
        end
        default: st_next = swdp_pkg::SWDP_LINE_RESET;
      endcase
    end
    // write commit at parity bit
    if (lnk.clk_rise && st_reg == swdp_pkg::SWDP_DATA && !req_rd &&
        cnt_reg == 6'd32 && ack_reg == swdp_pkg::ACK_OK) begin
      if (((^sh_reg[31:0]) ^ lnk.dio_level) != 1'b0) begin
        csr_next[swdp_pkg::CSR_WDE_BIT] = 1'b1;
      end else if (req_ap) begin
        busy_next = 8'(AP_LATENCY);
        wbuf_full_next = 1'b1;
      end else begin
        case (req_a)
          swdp_pkg::DP_ADDR_ID_ABORT: begin
            abort_next = sh_reg[swdp_pkg::ABORT_CUR];
            if (sh_reg[swdp_pkg::ABORT_CUR]) begin
              busy_next = 8'h0;
              wbuf_full_next = 1'b0;
            end
            if (sh_reg[swdp_pkg::ABORT_CMP])
              csr_next[swdp_pkg::CSR_CMP_BIT] = 1'b0;
            if (sh_reg[swdp_pkg::ABORT_ERR])
              csr_next[swdp_pkg::CSR_ERR_BIT] = 1'b0;
            if (sh_reg[swdp_pkg::ABORT_WDE])
              csr_next[swdp_pkg::CSR_WDE_BIT] = 1'b0;
            if (sh_reg[swdp_pkg::ABORT_ORUN])
              csr_next[swdp_pkg::CSR_ORUN_BIT] = 1'b0;
          end
          swdp_pkg::DP_ADDR_CTRL: begin
            if (sel_reg[swdp_pkg::SEL_CTRL_BIT]) begin
              wcr_next = sh_reg[31:0];
            end else begin
              csr_next = (csr_reg & ~swdp_pkg::CSR_WR_MASK) |
                (sh_reg[31:0] & swdp_pkg::CSR_WR_MASK);
            end
          end
          swdp_pkg::DP_ADDR_SELECT: begin
            sel_next = {8'h0, 16'h0, sh_reg[7:4], 3'h0, sh_reg[0]};
          end
          default: sel_next = sel_reg;
        endcase
      end
    end
    // read data load after acknowledge OK
    if (lnk.clk_rise && st_reg == swdp_pkg::SWDP_ACK && cnt_reg == 6'h2 &&
        req_rd && ack_reg == swdp_pkg::ACK_OK) begin
      if (req_ap) begin
        sh_next[31:0] = rdbuf_reg;
        rdbuf_next = ap_read(ap_addr);
        busy_next = 8'(AP_LATENCY);
        csr_next[swdp_pkg::CSR_READ_SUCCESS_FLAG_BIT] = 1'b1;
      end else begin
        case (req_a)
          swdp_pkg::DP_ADDR_ID_ABORT: begin
            sh_next[31:0] = ID_CODE;
            active_next = 1'b1;
          end
          swdp_pkg::DP_ADDR_CTRL: sh_next[31:0] =
            sel_reg[swdp_pkg::SEL_CTRL_BIT] ? wcr_reg : csr_reg;
          swdp_pkg::DP_ADDR_SELECT: sh_next[31:0] = resend_reg;
          default: begin
            sh_next[31:0] = rdbuf_reg;
            csr_next[swdp_pkg::CSR_READ_SUCCESS_FLAG_BIT] = 1'b1;
          end
        endcase
      end
      if (!(!req_ap && req_a == swdp_pkg::DP_ADDR_SELECT)) begin
        resend_next = sh_next[31:0];
      end
      sh_next[32] = ^sh_next[31:0];
    end
    // pin drive: change on falling link edge
    if (lnk.clk_fall) begin
      oe_next = 1'b0;
      if (st_reg == swdp_pkg::SWDP_ACK && ack_reg != 3'h0) begin
        oe_next = 1'b1;
        out_next = ack_reg[cnt_reg[1:0]];
      end else if (st_reg == swdp_pkg::SWDP_DATA && req_rd) begin
        oe_next = 1'b1;
        out_next = sh_reg[cnt_reg];
      end
    end
    if (hi_reg > 6'(swdp_pkg::LINE_RESET_HIGH_CYC) && lnk.dio_level) begin
      st_next = swdp_pkg::SWDP_LINE_RESET;
      cnt_next = 6'h0;
      active_next = 1'b0;
      oe_next = 1'b0;
    end
    if (lnk.clk_rise && !lnk.dio_level &&
        st_reg == swdp_pkg::SWDP_IDLE) begin
      cnt_next = 6'h0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= swdp_pkg::SWDP_LINE_RESET;
      cnt_reg <= 6'h0;
      hi_reg <= 6'h0;
      req_reg <= 8'h0;
      sh_reg <= 33'h0;
      ack_reg <= 3'h0;
      active_reg <= 1'b0;
      sel_reg <= swdp_pkg::SELECT_RESET;
      csr_reg <= swdp_pkg::CSR_RESET;
      wcr_reg <= swdp_pkg::WCR_RESET;
      rdbuf_reg <= 32'h0;
      resend_reg <= 32'h0;
      busy_reg <= 8'h0;
      wbuf_full_reg <= 1'b0;
      abort_reg <= 1'b0;
      out_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      hi_reg <= hi_next;
      req_reg <= req_next;
      sh_reg <= sh_next;
      ack_reg <= ack_next;
      active_reg <= active_next;
      sel_reg <= sel_next;
      csr_reg <= csr_next;
      wcr_reg <= wcr_next;
      rdbuf_reg <= rdbuf_next;
      resend_reg <= resend_next;
      busy_reg <= busy_next;
      wbuf_full_reg <= wbuf_full_next;
      abort_reg <= abort_next;
      out_reg <= out_next;
      oe_reg <= oe_next;
    end
  end

  assign swdio_out = out_reg;
  assign swdio_oe = oe_reg;
  assign dbg_abort = abort_reg;
  assign ctrl_stat = csr_reg;
  assign wire_ctrl = wcr_reg;
endmodule // swdp_port

// >>> swdp_pkg.sv
// package for the serial wire debug port: constants, types, offsets
// assumes nothing beyond a SystemVerilog compiler
package swdp_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned LINE_RESET_HIGH_CYC = 50;
  localparam int unsigned IDLE_LOW_CYC = 2;
  localparam logic [1:0] DP_ADDR_ID_ABORT = 2'h0;
  localparam logic [1:0] DP_ADDR_CTRL = 2'h1;
  localparam logic [1:0] DP_ADDR_SELECT = 2'h2;
  localparam logic [1:0] DP_ADDR_RDBUF = 2'h3;
  localparam logic [7:0] AP_IDENT_OFFSET = 8'hfc;
  localparam logic [2:0] ACK_OK = 3'h1;
  localparam logic [2:0] ACK_WAIT = 3'h2;
  localparam logic [2:0] ACK_FAULT = 3'h4;
  localparam int unsigned ABORT_CUR = 0;
  localparam int unsigned ABORT_CMP = 1;
  localparam int unsigned ABORT_ERR = 2;
  localparam int unsigned ABORT_WDE = 3;
  localparam int unsigned ABORT_ORUN = 4;
  localparam int unsigned SEL_CTRL_BIT = 0;
  localparam int unsigned SEL_BANK_LSB = 4;
  localparam logic [31:0] SELECT_RESET = 32'h0;
  localparam logic [31:0] CSR_RESET = 32'h0;
  localparam logic [31:0] WCR_RESET = 32'h0;
  localparam int unsigned CSR_ORUN_BIT = 1;
  localparam int unsigned CSR_READ_SUCCESS_FLAG_BIT = 6;
  localparam int unsigned CSR_CMP_BIT = 4;
  localparam int unsigned CSR_ERR_BIT = 5;
  localparam int unsigned CSR_WDE_BIT = 7;
  localparam int unsigned CSR_ORUNDET_BIT = 0;
  localparam logic [31:0] CSR_WR_MASK = 32'hf000_0f3d;
  localparam logic [3:0] AP_TYPE_MEM = 4'h8;
  typedef enum logic [2:0] {
    SWDP_LINE_RESET, SWDP_IDLE, SWDP_REQ, SWDP_TURN_ACK, SWDP_ACK,
    SWDP_DATA, SWDP_TURN_END
  } swdp_state_e;
endpackage

// >>> swdp_sync_if.sv
// carrier between the link sampler and the port core
// assumes both ends run on clk
interface swdp_sync_if;
  logic clk_rise;
  logic clk_fall;
  logic dio_level;
  modport sampler (output clk_rise, output clk_fall, output dio_level);
  modport core (input clk_rise, input clk_fall, input dio_level);
endinterface

// >>> swdp_link_sampler.sv
// three-stage sampler of the link clock and data pins, edge finder
// assumes link clock far slower than clk
module swdp_link_sampler (
  input wire logic clk,
  input wire logic nrst,
  input wire logic swclk,
  input wire logic swdio_in,
  swdp_sync_if.sampler lnk
);
  logic [2:0] ck_reg, ck_next;
  logic [2:0] dio_reg, dio_next;
  logic ck_lvl_reg, ck_lvl_next;
  logic dio_lvl_reg, dio_lvl_next;
  logic rise_reg, rise_next;
  logic fall_reg, fall_next;

  always_comb begin
    ck_next = {ck_reg[1:0], swclk};
    dio_next = {dio_reg[1:0], swdio_in};
    ck_lvl_next = ck_lvl_reg;
    dio_lvl_next = dio_lvl_reg;
    rise_next = 1'b0;
    fall_next = 1'b0;
    // change counts once stages two and three agree
    if (ck_reg[1] == ck_reg[2] && ck_reg[2] != ck_lvl_reg) begin
      ck_lvl_next = ck_reg[2];
      rise_next = ck_reg[2];
      fall_next = !ck_reg[2];
    end
    if (dio_reg[1] == dio_reg[2]) begin
      dio_lvl_next = dio_reg[2];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ck_reg <= 3'h0;
      dio_reg <= 3'h7;
      ck_lvl_reg <= 1'b0;
      dio_lvl_reg <= 1'b1;
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
    end else begin
      ck_reg <= ck_next;
      dio_reg <= dio_next;
      ck_lvl_reg <= ck_lvl_next;
      dio_lvl_reg <= dio_lvl_next;
      rise_reg <= rise_next;
      fall_reg <= fall_next;
    end
  end

  assign lnk.clk_rise = rise_reg;
  assign lnk.clk_fall = fall_reg;
  assign lnk.dio_level = dio_lvl_reg;
endmodule // swdp_link_sampler

// >>> swdp_monitor.sv
// checker on the debug port's pins and register outputs
// assumes binding to swdp_port, one clock domain on clk
module swdp_monitor (
  input wire logic clk,
  input wire logic nrst,
  input wire logic swclk,
  input wire logic swdio_in,
  input wire logic swdio_out,
  input wire logic swdio_oe,
  input wire logic dbg_abort,
  input wire logic [31:0] ctrl_stat,
  input wire logic [31:0] wire_ctrl
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  reset_values_a: assert property (
    $rose(nrst) |-> !swdio_oe && ctrl_stat == swdp_pkg::CSR_RESET)
    else $error("state not cleared by reset");
  abort_pulse_a: assert property (dbg_abort |=> !dbg_abort)
    else $error("abort pulse longer than one clock");
  abort_quiet_a: assert property (dbg_abort |-> !swdio_oe)
    else $error("abort while target drives");
  drive_start_a: assert property ($rose(swdio_oe) |-> !swclk)
    else $error("drive begins off the falling link edge");
  drive_end_a: assert property ($fell(swdio_oe) |-> !swclk)
    else $error("release off the falling link edge");
  bit_hold_a: assert property (
    swdio_oe && swclk |-> $stable(swdio_out))
    else $error("driven bit moved while link clock high");
  drive_min_a: assert property (
    $rose(swdio_oe) |-> swdio_oe [*8])
    else $error("driven bit shorter than half a link period");
  release_min_a: assert property (
    $fell(swdio_oe) |-> !swdio_oe [*8])
    else $error("turnaround too short");
  wcr_steady_a: assert property (swdio_oe |-> $stable(wire_ctrl))
    else $error("wire control changed during target drive");
endmodule // swdp_monitor

bind swdp_port swdp_monitor swdp_monitor_i (
  .clk(clk),
  .nrst(nrst),
  .swclk(swclk),
  .swdio_in(swdio_in),
  .swdio_out(swdio_out),
  .swdio_oe(swdio_oe),
  .dbg_abort(dbg_abort),
  .ctrl_stat(ctrl_stat),
  .wire_ctrl(wire_ctrl)
);

// >>> swdp_probe.sv
// debugger probe model: makes the link clock, sends requests and data
// assumes clk is the system clock; dio is the resolved data wire
module swdp_probe (
  input wire logic clk,
  input wire logic dio,
  output logic swclk,
  output logic dio_oe,
  output logic dio_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    swclk = 1'b0;
    dio_oe = 1'b1;
    dio_out = 1'b0;
  end
  // one link period of 16 clk, sampled just before the rising edge
  task automatic bit_cyc(input logic drv, input logic val,
                         output logic smp);
    swclk = 1'b0;
    dio_oe = drv;
    dio_out = val;
    repeat (8) @(posedge clk);
    #1;
    smp = dio;
    swclk = 1'b1;
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic line_reset();
    logic s;
    repeat (52) bit_cyc(1'b1, 1'b1, s);
    repeat (2) bit_cyc(1'b1, 1'b0, s);
  endtask
  task automatic xfer(input logic ap, input logic rnw,
      input logic [1:0] a, input logic [31:0] wd, input logic [1:0] bad,
      output logic [2:0] ack, output logic [31:0] rdata,
      output logic par_ok);
    logic [7:0] req;
    logic [32:0] d;
    logic s;
    req = {2'b10, ^{1'b1, ap, rnw, a} ^ bad[0], a, rnw, ap, 1'b1};
    for (int i = 0; i < 7; i++) bit_cyc(1'b1, req[i], s);
    bit_cyc(1'b0, 1'b1, s);
    bit_cyc(1'b0, 1'b1, s);
    for (int i = 0; i < 3; i++) begin
      bit_cyc(1'b0, 1'b1, s);
      ack[i] = s;
    end
    rdata = 32'h0;
    par_ok = 1'b0;
    if (ack == swdp_pkg::ACK_OK && rnw) begin
      for (int i = 0; i < 33; i++) begin
        bit_cyc(1'b0, 1'b1, s);
        d[i] = s;
      end
      rdata = d[31:0];
      par_ok = (^d[31:0]) == d[32];
      bit_cyc(1'b0, 1'b1, s);
    end else if (ack == swdp_pkg::ACK_OK) begin
      bit_cyc(1'b0, 1'b1, s);
      d = {^wd ^ bad[1], wd};
      for (int i = 0; i < 33; i++) bit_cyc(1'b1, d[i], s);
      repeat (2) bit_cyc(1'b1, 1'b0, s);
    end else begin
      bit_cyc(1'b0, 1'b1, s);
    end
  endtask
endmodule // swdp_probe

// >>> swdp_port_bench.sv
// self-checking bench for the serial wire debug port
// assumes swdp_probe as the debugger and a pull-up on the data wire
module swdp_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] ID = 32'h5a3c_0e71; // value is arbitrary
  localparam logic [3:0] REV = 4'h3; // value is arbitrary
  localparam logic [10:0] DES = 11'h2a6; // value is arbitrary
  localparam logic [7:0] APID = 8'h5c; // value is arbitrary
  localparam logic [31:0] AP_IDENT = {REV, DES, swdp_pkg::AP_TYPE_MEM,
                                      5'h0, APID};
  localparam logic [2:0] OK = swdp_pkg::ACK_OK;
  logic clk, nrst, swclk, p_oe, p_out, swdio_out, swdio_oe, dbg_abort;
  logic [31:0] ctrl_stat, wire_ctrl, rdata;
  wire dio = swdio_oe ? swdio_out : (p_oe ? p_out : 1'b1);
  int err_count = 0;
  int tests_run = 0;
  int aborts = 0;
  swdp_port #(.ID_CODE(ID), .AP_REVISION(REV), .AP_DESIGNER(DES),
    .AP_ID(APID), .AP_LATENCY(255)) swdp_port_i (
    .clk(clk), .nrst(nrst), .swclk(swclk), .swdio_in(dio),
    .swdio_out(swdio_out), .swdio_oe(swdio_oe), .dbg_abort(dbg_abort),
    .ctrl_stat(ctrl_stat), .wire_ctrl(wire_ctrl));
  swdp_probe swdp_probe_i (.clk(clk), .dio(dio), .swclk(swclk),
    .dio_oe(p_oe), .dio_out(p_out));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(negedge clk) if (dbg_abort === 1'b1) aborts++;
  task automatic summarize();
    if (err_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_ack(input logic [2:0] got, input logic [2:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t ack %b expected %b", $time, got, exp);
    end
  endtask
  task automatic op(input logic ap, input logic rnw, input logic [1:0] a,
      input logic [31:0] wd, input logic [1:0] bad, input logic [2:0] ea);
    logic [2:0] ack;
    logic pok;
    swdp_probe_i.xfer(ap, rnw, a, wd, bad, ack, rdata, pok);
    chk_ack(ack, ea);
    if (rnw && ea == OK) chk({31'h0, pok}, 32'h1);
  endtask
  function automatic logic [31:0] bit_of(input int unsigned b);
    return {31'h0, ctrl_stat[b]};
  endfunction
  initial begin
    nrst = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    nrst = 1'b1;
    chk(ctrl_stat, swdp_pkg::CSR_RESET);
    chk(wire_ctrl, swdp_pkg::WCR_RESET);
    swdp_probe_i.line_reset();
    op(0, 1, swdp_pkg::DP_ADDR_CTRL, 0, 0, swdp_pkg::ACK_FAULT);
    op(0, 1, swdp_pkg::DP_ADDR_ID_ABORT, 0, 0, OK);
    chk(rdata, ID);
    op(0, 0, swdp_pkg::DP_ADDR_SELECT, 32'h1, 0, OK);
    op(0, 0, swdp_pkg::DP_ADDR_CTRL, 32'h1, 0, OK);
    chk(wire_ctrl, 32'h1);
    op(0, 0, swdp_pkg::DP_ADDR_SELECT, 32'hffff_fff0, 0, OK);
    op(0, 0, swdp_pkg::DP_ADDR_CTRL, 32'h0f00, 0, OK);
    chk(ctrl_stat & 32'h0f00, 32'h0f00);
    chk(wire_ctrl, 32'h1);
    op(1, 1, 2'h3, 0, 0, OK);
    op(0, 1, swdp_pkg::DP_ADDR_RDBUF, 0, 0, OK);
    chk(rdata, AP_IDENT);
    chk(bit_of(swdp_pkg::CSR_READ_SUCCESS_FLAG_BIT), 32'h1);
    op(0, 1, swdp_pkg::DP_ADDR_SELECT, 0, 0, OK);
    chk(rdata, AP_IDENT);
    op(1, 1, 2'h3, 0, 0, OK);
    op(1, 1, 2'h3, 0, 0, OK);
    chk(rdata, AP_IDENT);
    op(0, 0, swdp_pkg::DP_ADDR_ID_ABORT, 32'h1, 0, OK);
    chk(aborts, 1);
    op(1, 0, 2'h0, 32'h55, 0, OK);
    op(1, 0, 2'h0, 32'haa, 0, swdp_pkg::ACK_WAIT);
    op(1, 0, 2'h0, 32'h55, 0, OK);
    op(0, 1, swdp_pkg::DP_ADDR_CTRL, 0, 0, OK);
    op(1, 0, 2'h0, 32'h55, 0, OK);
    op(0, 1, swdp_pkg::DP_ADDR_ID_ABORT, 0, 0, OK);
    op(1, 0, 2'h0, 32'h55, 0, OK);
    op(0, 0, swdp_pkg::DP_ADDR_ID_ABORT, 32'h1, 0, OK);
    chk(aborts, 2);
    op(0, 0, swdp_pkg::DP_ADDR_SELECT, 32'h1, 2'b10, OK);
    chk(bit_of(swdp_pkg::CSR_WDE_BIT), 32'h1);
    op(0, 0, swdp_pkg::DP_ADDR_ID_ABORT, 32'hffff_ffe0, 0, OK);
    chk(bit_of(swdp_pkg::CSR_WDE_BIT), 32'h1);
    chk(aborts, 2);
    op(0, 0, swdp_pkg::DP_ADDR_ID_ABORT, 32'h8, 0, OK);
    chk(bit_of(swdp_pkg::CSR_WDE_BIT), 32'h0);
    op(0, 1, swdp_pkg::DP_ADDR_ID_ABORT, 0, 2'b01, 3'h7);
    chk(bit_of(swdp_pkg::CSR_ERR_BIT), 32'h1);
    swdp_probe_i.line_reset();
    op(0, 1, swdp_pkg::DP_ADDR_CTRL, 0, 0, swdp_pkg::ACK_FAULT);
    op(0, 1, swdp_pkg::DP_ADDR_ID_ABORT, 0, 0, OK);
    op(1, 1, 2'h3, 0, 0, swdp_pkg::ACK_FAULT);
    op(0, 0, swdp_pkg::DP_ADDR_ID_ABORT, 32'h16, 0, OK);
    chk(bit_of(swdp_pkg::CSR_ERR_BIT), 32'h0);
    op(1, 1, 2'h3, 0, 0, OK);
    summarize();
  end
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    summarize();
  end
endmodule // swdp_port_bench
